/* File: hw/rxoq_pkg.sv */
// package: register map, fields and reset values of the receive output block
package rxoq_pkg;
    // printed offsets are not all multiples of four: index, byte = 4*index
    localparam logic [7:0]  IDX_PHASE_TRIM   = 8'h18;
    localparam logic [7:0]  IDX_EYE_READING  = 8'h19;
    localparam logic [7:0]  IDX_ALARM_SET    = 8'h1A;
    localparam logic [7:0]  IDX_ALARM_CLEAR  = 8'h1B;
    localparam logic [7:0]  IDX_PATH_CTRL    = 8'h1C;
    localparam logic [7:0]  IDX_STATUS       = 8'h1D;
    localparam logic [7:0]  IDX_FIFO_CTRL    = 8'h1E;

    localparam logic [6:0]  RST_PHASE_TRIM   = 7'h00;
    localparam logic [7:0]  RST_ALARM_SET    = 8'h29;
    localparam logic [5:0]  RST_ALARM_CLEAR  = 6'h0F;
    localparam logic [6:0]  RST_PATH_CTRL    = 7'h02;
    localparam logic [1:0]  ALARM_RSVD_VAL   = 2'h1;

    localparam int          BIT_INVERT       = 6;
    localparam int          BIT_CLK_ON_LOSS  = 5;
    localparam int          BIT_MUTE_LOL     = 4;
    localparam int          BIT_MUTE_LOS     = 3;
    localparam int          BIT_FORCE_MUTE   = 2;
    localparam int          BIT_AUTO_RECOVER = 1;
    localparam int          BIT_FLUSH        = 0;

    localparam int          PHASE_TRIM_PS    = 12;
    localparam int          SUBST_CLK_MHZ    = 622;

    localparam logic [4:0]  FIFO_CENTRE      = 5'h10;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

    typedef enum logic [1:0]
    {
        OUT_DATA   = 2'b00,
        OUT_CLOCK  = 2'b01,
        OUT_MUTED  = 2'b10
    } rxoq_out_t;
endpackage : rxoq_pkg

/* File: hw/rxoq_regs.sv */
// module: receive output path and quality alarm registers, AHB-Lite slave
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns

// What this block does
// - seven-bit signed phase trim, bit seven zero
// - trim codes span at least plus/minus 12 ps
// - read-only six-bit eye opening measure
// - alarm set level in bits 7:2, default ten
// - alarm clear level in low bits, default fifteen
// - invert bit flips the output data
// - clock on signal loss replaces data
// - lock loss mutes output when enabled
// - signal loss mutes output when enabled
// - force mute bit mutes unconditionally
// - auto recover recentres FIFO, clears error
// - without auto recover, FIFO left alone
// - flush bit recentres and clears FIFO
// - control register resets to auto recover only
module rxoq_regs
    import rxoq_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [5:0]  eye_opening_measure,
    input  wire logic        signal_loss,
    input  wire logic        lock_loss,
    input  wire logic        rx_data_in,
    input  wire logic        subst_clk_in,
    input  wire logic        fifo_error_in,
    output logic             rx_data_out,
    output logic      [6:0]  rx_sample_phase_offset,
    output logic             quality_alarm,
    output logic             fifo_recentre,
    output logic      [4:0]  fifo_pointer,
    output logic             fifo_error
);

    logic [7:0] alarm_set_r;
    logic [5:0] alarm_clear_r;
    logic [6:0] path_ctrl_r;
    logic [6:0] phase_r;
    logic       wr_pend_r;
    logic [7:0] wr_idx_r;
    logic       flush_req;
    logic       auto_req;

    wire  logic       acc = hsel && hready && htrans == HTRANS_NONSEQ;
    wire  logic [7:0] idx = haddr[9:2];

    // writes land in the data phase; no wait states, so hreadyout stays high
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
        end
        else
        begin
            wr_pend_r <= acc && hwrite;
            wr_idx_r  <= idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_r       <= RST_PHASE_TRIM;
            alarm_set_r   <= RST_ALARM_SET;
            alarm_clear_r <= RST_ALARM_CLEAR;
            path_ctrl_r   <= RST_PATH_CTRL;
        end
        else if (wr_pend_r)
        begin
            case (wr_idx_r)
                IDX_PHASE_TRIM:  phase_r <= hwdata[6:0];
                // reserved bits kept at 01 even if software slips
                IDX_ALARM_SET:   alarm_set_r <= {hwdata[7:2],
                                                 ALARM_RSVD_VAL};
                IDX_ALARM_CLEAR: alarm_clear_r <= hwdata[5:0];
                IDX_PATH_CTRL:   path_ctrl_r <= hwdata[6:0];
                default:         ;
            endcase
        end
        else
        begin
            // flush is self-clearing once the FIFO has been recentred
            path_ctrl_r[BIT_FLUSH] <= 1'b0;
        end
    end

    // trim code passes through one register to the phase interpolator, which
    // is sized so 7'h41 and 7'h3F reach the 12 ps ends
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rx_sample_phase_offset <= RST_PHASE_TRIM;
        else
            rx_sample_phase_offset <= phase_r;
    end

    // hysteresis: set below the set level, clear at the clear level
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            quality_alarm <= 1'b0;
        else if (eye_opening_measure < alarm_set_r[7:2])
            quality_alarm <= 1'b1;
        else if (eye_opening_measure >= alarm_clear_r)
            quality_alarm <= 1'b0;
    end

    assign flush_req = path_ctrl_r[BIT_FLUSH];
    assign auto_req  = path_ctrl_r[BIT_AUTO_RECOVER] && fifo_error_in;

    // error flag: a new error outranks an automatic clear only when
    // recovery is off; with recovery on the FIFO restart removes the cause
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fifo_error    <= 1'b0;
            fifo_recentre <= 1'b0;
            fifo_pointer  <= FIFO_CENTRE;
        end
        else
        begin
            fifo_recentre <= flush_req || auto_req;
            if (auto_req)
            begin
                fifo_error   <= 1'b0;
                fifo_pointer <= FIFO_CENTRE;
            end
            else if (fifo_error_in)
                fifo_error <= 1'b1;
            else if (flush_req)
                fifo_pointer <= FIFO_CENTRE;
        end
    end

    rxoq_out_t mode;
    always_comb
    begin
        if (path_ctrl_r[BIT_FORCE_MUTE])
            mode = OUT_MUTED;
        else if (path_ctrl_r[BIT_MUTE_LOL] && lock_loss)
            mode = OUT_MUTED;
        else if (path_ctrl_r[BIT_MUTE_LOS] && signal_loss)
            mode = OUT_MUTED;
        else if (path_ctrl_r[BIT_CLK_ON_LOSS] && signal_loss)
            mode = OUT_CLOCK;
        else
            mode = OUT_DATA;
    end

    // mute drives a fixed low; it wins over the substitute clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rx_data_out <= 1'b0;
        else
        begin
            case (mode)
                OUT_MUTED: rx_data_out <= 1'b0;
                OUT_CLOCK: rx_data_out <= subst_clk_in;
                OUT_DATA:  rx_data_out <= rx_data_in ^
                                          path_ctrl_r[BIT_INVERT];
                default:   rx_data_out <= 1'b0;
            endcase
        end
    end

    // read data driven in the data phase, one cycle after the address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (acc && !hwrite)
            begin
                case (idx)
                    IDX_PHASE_TRIM:  hrdata <= {25'h0, phase_r};
                    IDX_EYE_READING: hrdata <= {26'h0,
                                                eye_opening_measure};
                    IDX_ALARM_SET:   hrdata <= {24'h0, alarm_set_r};
                    IDX_ALARM_CLEAR: hrdata <= {26'h0, alarm_clear_r};
                    IDX_PATH_CTRL:   hrdata <= {25'h0, path_ctrl_r};
                    IDX_STATUS:      hrdata <= {29'h0, fifo_error,
                                                lock_loss, signal_loss};
                    IDX_FIFO_CTRL:   hrdata <= {26'h0, quality_alarm,
                                                fifo_pointer};
                    default:         hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : rxoq_regs

/* File: verification/rxoq_monitor.sv */
// checker: bus response and receive output selection
`timescale 1ns/1ns
module rxoq_monitor
    import rxoq_pkg::*;
(
    input wire logic        hclk, hresetn, hsel, hwrite, hresp,
    input wire logic [31:0] haddr, hwdata,
    input wire logic [1:0]  htrans,
    input wire logic        signal_loss, lock_loss, rx_data_in, subst_clk_in,
    input wire logic        fifo_error_in, rx_data_out, fifo_recentre,
    input wire logic        fifo_error
);
    logic       pend_r, mute, subst;
    logic [7:0] ctrl_r;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // control mirror, loaded in the data phase like the real register
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            pend_r <= 1'h0;
        else
            pend_r <= hsel && htrans == HTRANS_NONSEQ && hwrite
                && haddr[9:2] == IDX_PATH_CTRL;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            ctrl_r <= 8'h02;
        else if (pend_r)
            ctrl_r <= hwdata[7:0];
    assign mute = ctrl_r[2] || ctrl_r[4] && lock_loss
        || ctrl_r[3] && signal_loss;
    assign subst = ctrl_r[5] && signal_loss;
    a_resp_okay: assert property (hresp == 1'h0) else $error("bad response");
    a_force_mute: assert property (ctrl_r[2] |=> !rx_data_out)
        else $error("force mute");
    a_lock_mute:
        assert property (ctrl_r[4] && lock_loss |=> !rx_data_out)
        else $error("lock mute");
    a_loss_mute:
        assert property (ctrl_r[3] && signal_loss |=> !rx_data_out)
        else $error("loss mute");
    a_clock_subst:
        assert property (!mute && subst |=> rx_data_out == $past(subst_clk_in))
        else $error("clock substitute");
    a_data_path: assert property (!mute && !subst |=>
        rx_data_out == ($past(rx_data_in) ^ $past(ctrl_r[6])))
        else $error("data path");
    a_auto_recover:
        assert property (ctrl_r[1] && fifo_error_in |-> ##[1:3] fifo_recentre)
        else $error("no recovery");
    a_error_kept: assert property (!ctrl_r[1] && fifo_error_in |=> fifo_error)
        else $error("error flag lost");
    c_muted: cover property (mute ##1 !rx_data_out);
    c_subst: cover property (subst && !mute);
    c_recover: cover property (ctrl_r[1] && fifo_recentre);
endmodule : rxoq_monitor

/* File: verification/rxoq_host_rx.sv */
// model: host receiver retiming the recovered serial data
`timescale 1ns/1ns
module rxoq_host_rx
(
    input  wire logic hclk,
    input  wire logic rd,
    output logic      seen
);
    // one retiming flop, as a real host input would sample it
    always_ff @(posedge hclk)
        seen <= rd;
endmodule : rxoq_host_rx

/* File: verification/tb_rx_output_path_and_quality_control.sv */
// testbench: registers, output path and alarm of the receive block
`timescale 1ns/1ns
module tb_rx_output_path_and_quality_control;
    import rxoq_pkg::*;
    logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
    logic        signal_loss = 1'h0, lock_loss = 1'h0, rx_data_in = 1'h0;
    logic        subst_clk_in = 1'h0, fifo_error_in = 1'h0, seen, hresp;
    logic        hreadyout, rx_data_out, quality_alarm, fifo_recentre;
    logic        fifo_error;
    logic [1:0]  htrans = 2'h0;
    logic [4:0]  fifo_pointer;
    logic [5:0]  eye_opening_measure = 6'h3F;
    logic [6:0]  rx_sample_phase_offset;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    int          n_fail = 0, cmp_count = 0;
    // control, {loss, lock loss, data, clock}, eye; expect {out, alarm}
    logic [17:0] row [7] = '{{8'h00, 4'h2, 6'h3F}, {8'h40, 4'h2, 6'h0C},
        {8'h20, 4'h9, 6'h09}, {8'h24, 4'hB, 6'h0E}, {8'h10, 4'h6, 6'h0F},
        {8'h08, 4'hA, 6'h03}, {8'h28, 4'hB, 6'h14}};
    logic [1:0]  ex [7] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h0, 2'h1, 2'h0};
    always #25 hclk = ~hclk;
    rxoq_regs u_rxoq_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .eye_opening_measure, .signal_loss, .lock_loss, .rx_data_in,
        .subst_clk_in, .fifo_error_in, .rx_data_out, .rx_sample_phase_offset,
        .quality_alarm, .fifo_recentre, .fifo_pointer, .fifo_error);
    rxoq_host_rx u_rxoq_host_rx (.hclk, .rd(rx_data_out), .seen);
    task automatic bus(input logic w, input logic [7:0] i,
                       input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {22'h0, i, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask : bus
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] i, input logic [31:0] e);
        bus(1'h0, i, 32'h0);
        chk("hrdata", e, q);
    endtask : rchk
    task finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        for (int i = 0; i < 7; i++)
        begin
            bus(1'h1, IDX_PATH_CTRL, {24'h0, row[i][17:10]});
            {signal_loss, lock_loss, rx_data_in, subst_clk_in} <= row[i][9:6];
            eye_opening_measure <= row[i][5:0];
            repeat (3) @(posedge hclk);
            chk("rx_out", {31'h0, ex[i][1]}, {31'h0, seen});
            chk("alarm", {31'h0, ex[i][0]}, {31'h0, quality_alarm});
        end
        hresetn <= 1'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        rchk(IDX_PATH_CTRL, 32'h02);
        rchk(IDX_ALARM_SET, 32'h29);
        rchk(IDX_ALARM_CLEAR, 32'h0F);
        bus(1'h1, IDX_EYE_READING, 32'h0);
        rchk(IDX_EYE_READING, {26'h0, eye_opening_measure});
        rchk(8'h1F, 32'h0);
        bus(1'h1, IDX_PHASE_TRIM, 32'hC1);
        rchk(IDX_PHASE_TRIM, 32'h41);
        chk("trim", 32'h41, {25'h0, rx_sample_phase_offset});
        bus(1'h1, IDX_ALARM_SET, 32'h31);
        rchk(IDX_ALARM_SET, 32'h31);
        bus(1'h1, IDX_PATH_CTRL, 32'h03);
        for (int k = 0; k < 4 && fifo_recentre !== 1'h1; k++) @(negedge hclk);
        chk("recentre", 32'h1, {31'h0, fifo_recentre});
        chk("pointer", {27'h0, FIFO_CENTRE}, {27'h0, fifo_pointer});
        @(posedge hclk);
        fifo_error_in <= 1'h1;
        repeat (3) @(posedge hclk);
        chk("fifo_error", 32'h0, {31'h0, fifo_error});
        bus(1'h1, IDX_PATH_CTRL, 32'h00);
        repeat (3) @(posedge hclk);
        chk("fifo_error", 32'h1, {31'h0, fifo_error});
        rchk(IDX_STATUS, 32'h5);
        rchk(IDX_FIFO_CTRL, {27'h0, FIFO_CENTRE});
        finish_test;
    end
    initial
    begin
        repeat (3000) @(posedge hclk);
        n_fail++;
        finish_test;
    end
endmodule : tb_rx_output_path_and_quality_control
bind rxoq_regs rxoq_monitor u_rxoq_monitor (.hclk, .hresetn, .hsel, .hwrite,
    .hresp, .haddr, .hwdata, .htrans, .signal_loss, .lock_loss, .rx_data_in,
    .subst_clk_in, .fifo_error_in, .rx_data_out, .fifo_recentre, .fifo_error);
